/* logic/gpb_detect.sv */
// per-pin interrupt condition detector
`timescale 1ns/100ps
module gpb_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin_level,
  input wire logic [WIDTH-1:0] irq_sense_select,
  input wire logic [WIDTH-1:0] irq_both_edges,
  input wire logic [WIDTH-1:0] irq_event_polarity,
  output logic [WIDTH-1:0] edge_hit,
  output logic [WIDTH-1:0] level_hit
);
  logic [WIDTH-1:0] last_level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  // previous synchronised level for edge compare
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      last_level <= '0;
    else
      last_level <= pin_level;
  end

  assign rise = pin_level & ~last_level;
  assign fall = ~pin_level & last_level;

  // sense picks edge or level; both-edges overrides polarity
  always_comb
  begin
    edge_hit = ~irq_sense_select & (irq_both_edges & (rise | fall)
      | ~irq_both_edges & (irq_event_polarity & rise
      | ~irq_event_polarity & fall));
    level_hit = irq_sense_select & ~(pin_level ^ irq_event_polarity);
  end
endmodule

/* logic/gpb_port.sv */
// general-purpose i/o port: direction, masked data, interrupts, pads
`timescale 1ns/100ps
module gpb_port
  import gpb_pkg::*;
#(
  parameter int WIDTH = gpb_pkg::PIN_COUNT,
  parameter logic [7:0] ALT_RESET = gpb_pkg::ALT_RESET_PLAIN,
  parameter bit IS_PORT_B = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_write,
  input wire logic data_read,
  input wire logic [gpb_pkg::ADDR_WIDTH-1:0] data_addr,
  input wire logic [WIDTH-1:0] data_wdata,
  output logic [WIDTH-1:0] data_rdata,
  input wire logic [WIDTH-1:0] pin_direction,
  input wire logic alt_write,
  input wire logic [WIDTH-1:0] alt_wdata,
  output logic [WIDTH-1:0] alt_function_select,
  input wire logic [WIDTH-1:0] irq_sense_select,
  input wire logic [WIDTH-1:0] irq_both_edges,
  input wire logic [WIDTH-1:0] irq_event_polarity,
  input wire logic [WIDTH-1:0] irq_mask,
  input wire logic irq_clear_write,
  input wire logic [WIDTH-1:0] irq_clear,
  output logic [WIDTH-1:0] irq_raw_status,
  output logic [WIDTH-1:0] irq_masked_status,
  output logic port_irq,
  output logic converter_trigger,
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_oe,
  output logic [WIDTH-1:0] periph_in,
  input wire logic pad_write,
  input wire logic [WIDTH-1:0] pad_drive_2ma_wdata,
  input wire logic [WIDTH-1:0] pad_drive_4ma_wdata,
  input wire logic [WIDTH-1:0] pad_drive_8ma_wdata,
  input wire logic [WIDTH-1:0] pad_open_drain_wdata,
  input wire logic [WIDTH-1:0] pad_pull_up_wdata,
  input wire logic [WIDTH-1:0] pad_pull_down_wdata,
  input wire logic [WIDTH-1:0] pad_slew_wdata,
  input wire logic [WIDTH-1:0] pad_digital_enable_wdata,
  output logic [WIDTH-1:0] pad_drive_2ma,
  output logic [WIDTH-1:0] pad_drive_4ma,
  output logic [WIDTH-1:0] pad_drive_8ma,
  output logic [WIDTH-1:0] pad_open_drain,
  output logic [WIDTH-1:0] pad_pull_up,
  output logic [WIDTH-1:0] pad_pull_down,
  output logic [WIDTH-1:0] pad_slew,
  output logic [WIDTH-1:0] pad_digital_enable,
  output logic [7:0] id_byte_0,
  output logic [7:0] id_byte_2
);
  import gpb_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // decodes the per-bit mask carried on address bits 9..2
  function automatic logic [WIDTH-1:0] addr_mask(
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [7:0] bits;
    bits = addr[MASK_MSB:MASK_LSB];
    return bits[WIDTH-1:0];
  endfunction

  logic [WIDTH-1:0] pad_sync;
  logic [WIDTH-1:0] port_data;
  logic [WIDTH-1:0] edge_hit;
  logic [WIDTH-1:0] level_hit;
  logic [WIDTH-1:0] edge_pending;
  logic [WIDTH-1:0] data_mask;
  logic data_hit;
  logic [WIDTH-1:0] clear_bits;

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // pads cross in from outside the clock domain
  gpb_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // peripherals see the synchronised pad level too
  assign periph_in = pad_sync;

  // ----------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------
  assign data_hit = data_addr <= DATA_REGION_TOP;
  assign data_mask = addr_mask(data_addr);

  // inputs track the pad; outputs keep software's value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      port_data <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (!pin_direction[i])
          port_data[i] <= pad_sync[i];
        else if (data_write && data_hit && data_mask[i])
          port_data[i] <= data_wdata[i];
      end
    end
  end

  // registered read; unmasked bits read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_rdata <= '0;
    else if (data_read && data_hit)
      data_rdata <= port_data & data_mask;
    else
      data_rdata <= '0;
  end

  // ----------------------------------------------------------------
  // mode and pad drive
  // ----------------------------------------------------------------
  // any reset brings the debug pins back to their peripheral
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alt_function_select <= ALT_RESET;
    else if (alt_write)
      alt_function_select <= alt_wdata;
  end

  // in port mode open drain only pulls low, so enable follows inverted data; alternate pins take periph_oe
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      if (alt_function_select[i])
      begin
        pad_out[i] = periph_out[i];
        pad_oe[i] = periph_oe[i] & pad_digital_enable[i];
      end
      else
      begin
        pad_out[i] = port_data[i];
        pad_oe[i] = pin_direction[i] & pad_digital_enable[i]
          & ~(pad_open_drain[i] & port_data[i]);
      end
    end
  end

  // pad settings, written together as one group
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pad_drive_2ma <= DRIVE2_RESET;
      pad_drive_4ma <= ZERO_BYTE;
      pad_drive_8ma <= ZERO_BYTE;
      pad_open_drain <= ZERO_BYTE;
      pad_pull_up <= PULLUP_RESET;
      pad_pull_down <= ZERO_BYTE;
      pad_slew <= ZERO_BYTE;
      pad_digital_enable <= DIGEN_RESET;
    end
    else if (pad_write)
    begin
      pad_drive_2ma <= pad_drive_2ma_wdata;
      pad_drive_4ma <= pad_drive_4ma_wdata;
      pad_drive_8ma <= pad_drive_8ma_wdata;
      pad_open_drain <= pad_open_drain_wdata;
      pad_pull_up <= pad_pull_up_wdata;
      pad_pull_down <= pad_pull_down_wdata;
      pad_slew <= pad_slew_wdata;
      pad_digital_enable <= pad_digital_enable_wdata;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  gpb_detect #(
    .WIDTH(WIDTH)
  ) u_detect (
    .clk(clk),
    .rst_b(rst_b),
    .pin_level(pad_sync),
    .irq_sense_select(irq_sense_select),
    .irq_both_edges(irq_both_edges),
    .irq_event_polarity(irq_event_polarity),
    .edge_hit(edge_hit),
    .level_hit(level_hit)
  );

  // ----------------------------------------------------------------
  // settling after reset
  // ----------------------------------------------------------------
  // the synchroniser and the last-level store both restart at zero,
  // so a pad held high through reset would look like a rising edge;
  // edges are ignored until the whole input pipeline holds real levels
  localparam int SETTLE_EDGES = SYNC_STAGES + 1;
  localparam logic [1:0] SETTLE_DONE = 2'(SETTLE_EDGES);

  logic [1:0] settle_count;
  logic inputs_settled;
  logic [WIDTH-1:0] edge_seen;
  logic [WIDTH-1:0] next_pending;

  // counts edges after reset release, then stays at its end value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_count <= '0;
    else if (!inputs_settled)
      settle_count <= settle_count + 2'h1;
  end

  // only a few cycles are lost, and only right after reset
  assign inputs_settled = settle_count == SETTLE_DONE;

  // level conditions need no such guard: they follow the settled pin
  assign edge_seen = inputs_settled ? edge_hit : '0;

  assign clear_bits = irq_clear_write ? irq_clear : '0;

  // a new edge in the clear cycle wins, so no event is lost
  assign next_pending = edge_seen | (edge_pending & ~clear_bits);

  // pending edges wait here for software's clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      edge_pending <= '0;
    else
      edge_pending <= next_pending;
  end

  // level causes are not latched: they follow the pin
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_raw_status <= '0;
      irq_masked_status <= '0;
    end
    else
    begin
      irq_raw_status <= next_pending | level_hit;
      irq_masked_status <= (next_pending | level_hit) & irq_mask;
    end
  end

  // one line out for the whole port
  assign port_irq = |irq_masked_status;

  // converter trigger from an unmasked pin 4 on port b only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      converter_trigger <= 1'b0;
    else
      converter_trigger <= IS_PORT_B
        && (edge_seen[TRIGGER_PIN] || level_hit[TRIGGER_PIN])
        && irq_mask[TRIGGER_PIN];
  end

  // ----------------------------------------------------------------
  // identification
  // ----------------------------------------------------------------
  assign id_byte_0 = ID_BYTE_0;
  assign id_byte_2 = ID_BYTE_2;
endmodule

/* logic/gpb_sync.sv */
// two-stage synchroniser for the pad inputs
`timescale 1ns/100ps
module gpb_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

/* shared/gpb_pkg.sv */
// constants shared by the general-purpose port block
package gpb_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 12;
  // data region: address bits [9:2] mask the data bits
  localparam int MASK_LSB = 2;
  localparam int MASK_MSB = 9;
  localparam logic [ADDR_WIDTH-1:0] DATA_REGION_TOP = 12'h3FC;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] ALT_RESET_PLAIN = 8'h00;
  // debug pins: port b pin 7, port c pins 3..0
  localparam logic [7:0] ALT_RESET_PORT_B = 8'h80;
  localparam logic [7:0] ALT_RESET_PORT_C = 8'h0F;
  localparam logic [7:0] DRIVE2_RESET = 8'hFF;
  localparam logic [7:0] PULLUP_RESET = 8'hFF;
  localparam logic [7:0] DIGEN_RESET = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int TRIGGER_PIN = 4;
  // identification bytes; values arbitrary
  localparam logic [7:0] ID_BYTE_0 = 8'h5A;
  localparam logic [7:0] ID_BYTE_2 = 8'hA5;
  localparam int SYNC_STAGES = 2;
endpackage

/* sim/gpb_pad_model.sv */
// pad-side model: external circuitry on the port pads
`timescale 1ns/100ps
module gpb_pad_model (
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  // a driven pad shows the port, else the source holds its level steady
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

/* sim/gpb_port_checker.sv */
// concurrent checks on the ports of the general-purpose port block
`timescale 1ns/100ps
module gpb_port_checker
  import gpb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_read,
  input wire logic [gpb_pkg::ADDR_WIDTH-1:0] data_addr,
  input wire logic [7:0] data_rdata,
  input wire logic [7:0] pin_direction,
  input wire logic alt_write,
  input wire logic [7:0] alt_wdata,
  input wire logic [7:0] alt_function_select,
  input wire logic [7:0] irq_sense_select,
  input wire logic [7:0] irq_mask,
  input wire logic irq_clear_write,
  input wire logic [7:0] irq_clear,
  input wire logic [7:0] irq_raw_status,
  input wire logic [7:0] irq_masked_status,
  input wire logic port_irq,
  input wire logic converter_trigger,
  input wire logic [7:0] pad_oe
);
  // ----------------------------------------
  // port properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // a read request, answered on the following edge
  sequence s_read;
    data_read;
  endsequence
  a_read_mask_zero: assert property (
    s_read |=> (data_rdata & ~$past(data_addr[MASK_MSB:MASK_LSB])) == 8'h00)
    else $error("read leaks unmasked bits");
  a_read_idle_zero: assert property (
    !data_read |=> data_rdata == 8'h00)
    else $error("read data without request");
  // level sense pins may drop by themselves, edge pins only by a clear
  a_edge_holds: assert property (
    $fell(irq_raw_status[0]) && !$past(irq_sense_select[0])
      && !$past(irq_sense_select[0], 2)
      |-> $past(irq_clear_write) && $past(irq_clear[0]))
    else $error("edge status dropped without clear");
  a_trig_needs_mask: assert property (
    !irq_mask[TRIGGER_PIN] && !$past(irq_mask[TRIGGER_PIN])
      |-> !converter_trigger)
    else $error("trigger while masked");
  a_irq_is_or: assert property (
    port_irq == |(irq_raw_status & $past(irq_mask)))
    else $error("port interrupt not or of status");
  a_mask_hides: assert property (
    irq_mask == 8'h00 && $past(irq_mask) == 8'h00
      |-> irq_masked_status == 8'h00)
    else $error("masked status set while masked");
  a_oe_needs_dir: assert property (
    (pad_oe & ~pin_direction & ~alt_function_select) == 8'h00)
    else $error("input pin driven");
  a_alt_loads: assert property (
    alt_write |=> alt_function_select == $past(alt_wdata))
    else $error("alternate select not loaded");
endmodule

bind gpb_port gpb_port_checker chk (
  .clk, .rst_b, .data_read, .data_addr, .data_rdata, .pin_direction,
  .alt_write, .alt_wdata, .alt_function_select, .irq_sense_select,
  .irq_mask, .irq_clear_write, .irq_clear, .irq_raw_status,
  .irq_masked_status, .port_irq, .converter_trigger, .pad_oe
);

/* sim/tb_gpb_port.sv */
// self-checking testbench for the general-purpose port block
`timescale 1ns/100ps
module tb_gpb_port;
  import gpb_pkg::*;
  logic clk = 0, rst_b = 0, data_write = 0, data_read = 0, alt_write = 0;
  logic irq_clear_write = 0, pad_write = 0, port_irq, converter_trigger;
  logic [ADDR_WIDTH-1:0] data_addr = '0;
  logic [7:0] data_wdata = 0, pin_direction = 0, alt_wdata = 0, pad_w = 0;
  logic [7:0] irq_sense_select = 0, irq_both_edges = 0, irq_mask = 0;
  logic [7:0] irq_event_polarity = 0, irq_clear = 0, ext_level = 0, hits;
  logic [7:0] per_o = 8'h80, per_oe = 8'hFF, data_rdata, pad_in, pad_out;
  logic [7:0] alt_function_select, irq_raw_status, irq_masked_status;
  logic [7:0] pad_oe, periph_in, pad_drive_2ma, pad_pull_up;
  logic [7:0] pad_digital_enable;
  logic [7:0] pad_drive_4ma, pad_drive_8ma, pad_open_drain, pad_pull_down;
  logic [7:0] pad_slew, id_byte_0, id_byte_2;
  // sense, both, event, start level, end level, expected raw bit
  logic [5:0] modes [8] = '{6'b001011, 6'b000101, 6'b000010, 6'b010101,
    6'b010011, 6'b101011, 6'b100101, 6'b101100};
  int errors = 0, comparisons = 0;
  always #4 clk = ~clk;
  gpb_port #(.ALT_RESET(ALT_RESET_PORT_B), .IS_PORT_B(1'b1)) uut (
    .clk, .rst_b, .data_write, .data_read, .data_addr, .data_wdata,
    .data_rdata, .pin_direction, .alt_write, .alt_wdata,
    .alt_function_select, .irq_sense_select, .irq_both_edges,
    .irq_event_polarity, .irq_mask, .irq_clear_write, .irq_clear,
    .irq_raw_status, .irq_masked_status, .port_irq, .converter_trigger,
    .pad_in, .pad_out, .pad_oe, .periph_out(per_o), .periph_oe(per_oe),
    .periph_in, .pad_write, .pad_drive_2ma_wdata(pad_w),
    .pad_drive_4ma_wdata(pad_w), .pad_drive_8ma_wdata(pad_w),
    .pad_open_drain_wdata(pad_w), .pad_pull_up_wdata(pad_w),
    .pad_pull_down_wdata(pad_w), .pad_slew_wdata(pad_w),
    .pad_digital_enable_wdata(pad_w), .pad_drive_2ma, .pad_drive_4ma,
    .pad_drive_8ma, .pad_open_drain, .pad_pull_up, .pad_pull_down,
    .pad_slew, .pad_digital_enable, .id_byte_0, .id_byte_2
  );
  gpb_pad_model pm (.pad_out, .pad_oe, .ext_level, .pad_in);
  // ----------------------------------------
  // access tasks: inputs move 1 ns after the edge
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each task idles one edge at its end so strobes never re-rise at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    data_write = 1;
    data_addr = a;
    data_wdata = d;
    tick(1);
    data_write = 0;
    tick(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    data_read = 1;
    data_addr = a;
    tick(1);
    data_read = 0;
    check(data_rdata, exp);
    tick(1);
  endtask
  task automatic clr(input logic [7:0] m);
    irq_clear_write = 1;
    irq_clear = m;
    tick(1);
    irq_clear_write = 0;
    tick(1);
  endtask
  task automatic alt(input logic [7:0] v);
    alt_wdata = v;
    alt_write = 1;
    tick(1);
    alt_write = 0;
    tick(1);
  endtask
  // the debug reset pin is kept high while reset is applied
  task automatic do_reset();
    rst_b = 0;
    ext_level[7] = 1'b1;
    tick(2);
    rst_b = 1;
    tick(3);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    do_reset();
    check(alt_function_select, ALT_RESET_PORT_B);
    check(pad_oe, 8'h80);
    check(pad_out & 8'h80, 8'h80);
    check(pad_drive_2ma & pad_pull_up & pad_digital_enable, 8'hFF);
    check(pad_drive_4ma | pad_drive_8ma | pad_open_drain, 8'h00);
    check(pad_pull_down | pad_slew, 8'h00);
    check(id_byte_0, ID_BYTE_0);
    check(id_byte_2, ID_BYTE_2);
    $display("test reset done");
    alt(8'h00);
    check(alt_function_select, 8'h00);
    pin_direction = 8'hFF;
    wr(12'h3FC, 8'hFF);
    wr(12'h098, 8'hEB);
    rd(12'h3FC, 8'hFB);
    rd(12'h0C4, 8'h31);
    check(pad_out, 8'hFB);
    check(pad_oe, 8'hFF);
    wr(12'h000, 8'h00);
    wr(12'h7FC, 8'h00);
    rd(12'h3FC, 8'hFB);
    rd(12'h7FC, 8'h00);
    do_reset();
    check(alt_function_select, ALT_RESET_PORT_B);
    rd(12'h3FC, 8'h00);
    $display("test data done");
    alt(8'h00);
    pin_direction = 8'h00;
    ext_level = 8'h5A;
    tick(4);
    rd(12'h3FC, 8'h5A);
    check(periph_in, 8'h5A);
    // two rising edges on pin 0, unmasked
    irq_event_polarity = 8'h01;
    irq_mask = 8'h01;
    ext_level = 8'h00;
    tick(4);
    clr(8'hFF);
    ext_level = 8'h01;
    tick(4);
    check(irq_raw_status, 8'h01);
    check({7'h0, port_irq}, 8'h01);
    ext_level = 8'h00;
    tick(4);
    ext_level = 8'h01;
    tick(4);
    check(irq_masked_status, 8'h01);
    clr(8'hFE);
    check(irq_raw_status, 8'h01);
    clr(8'h01);
    check(irq_raw_status, 8'h00);
    check({7'h0, port_irq}, 8'h00);
    $display("test edge done");
    // trigger modes on pin 0 with the mask closed first
    irq_mask = 8'h00;
    foreach (modes[i])
    begin
      {irq_sense_select[0], irq_both_edges[0], irq_event_polarity[0],
        ext_level[0]} = modes[i][5:2];
      tick(4);
      clr(8'hFF);
      ext_level[0] = modes[i][1];
      tick(4);
      check(irq_raw_status, {7'h0, modes[i][0]});
      check(irq_masked_status, 8'h00);
    end
    $display("test modes done");
    irq_sense_select = 8'h00;
    irq_both_edges = 8'h00;
    irq_event_polarity = 8'h10;
    irq_mask = 8'h10;
    ext_level = 8'h00;
    tick(4);
    clr(8'hFF);
    hits = 8'h00;
    ext_level = 8'h10;
    repeat (6)
    begin
      tick(1);
      hits = hits + {7'h0, converter_trigger};
    end
    check(hits, 8'h01);
    check({7'h0, port_irq}, 8'h01);
    $display("test trigger done");
    pad_w = 8'h3C;
    pad_write = 1;
    tick(1);
    pad_write = 0;
    tick(1);
    check(pad_digital_enable & pad_pull_up, 8'h3C);
    check(pad_drive_4ma & pad_drive_8ma & pad_slew, 8'h3C);
    check(pad_drive_2ma & pad_pull_down, 8'h3C);
    // open drain lets go of the pin holding a one; disabled pads float
    pin_direction = 8'hFF;
    tick(1);
    check(pad_oe, 8'h2C);
    $display("test pads done");
    end_of_test();
  end
  // watchdog well beyond the 155 or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule
